// ### rcs_reset_sequencer.sv
`timescale 1ns/1ps
// Behaviour
// - Both requests together give master reset
// - Request alone resets all but DRAM
// - Both request inputs pass two-flop synchroniser
// - Reset out holds, then 32 cycles more
// - Tristate bus until first exception cycle
// - Master reset ends all cycles, refresh too
// - Normal, watchdog resets keep DRAM refresh
// - Every reset initialises core registers
// - External reset sets hard, clears soft
// - Watchdog reset clears hard, sets soft
// - Master reset latches straps, last asserted cycle
// - Normal reset latches straps, last asserted cycle
// - Watchdog internal reset at least 31 clocks
// - Reset out 31 cycles past watchdog reset
// - Straps not sampled in watchdog reset
module rcs_reset_sequencer
   import rcs_pkg::*;
(
   // Clock, reset, enable
   input  wire logic                   clock,
   input  wire logic                   rst_b,
   input  wire logic                   clk_en,
   // External reset pins, requests active low, straps level, asynchronous
   input  wire logic                   reset_request_in_b,
   input  wire logic                   tristate_request_in_b,
   input  wire logic [RCS_STRAP_W-1:0] level_strap_pins,
   // Watchdog timeout event, same clock
   input  wire logic                   wdog_timeout,
   // Core reaches its first reset-exception bus cycle
   input  wire logic                   first_exception_cycle,
   // Reset outputs
   output logic                        reset_out_b,
   output logic                        core_reset,
   output logic                        dram_ctrl_reset,
   output logic                        bus_tristate,
   // Cause flags and chip select 0 strap configuration
   output logic                        hard_reset_flag,
   output logic                        soft_reset_flag,
   output logic [RCS_STRAP_W-1:0]      chip_select0_strap
);

   // Synchroniser stages; stage one is read only by stage two
   logic                   rreq_s1_r,  rreq_s2_r;
   logic                   treq_s1_r,  treq_s2_r;
   logic [RCS_STRAP_W-1:0] strap_s1_r, strap_s2_r;

   // Sequencer state and stretch counter
   rcs_state_t             state_r,    state_nxt;
   logic [RCS_CNT_W-1:0]   cnt_r,      cnt_nxt;

   // Reset cause, master marker and strap copy
   logic                   master_r,   master_nxt;
   logic                   hard_r,     hard_nxt;
   logic                   soft_r,     soft_nxt;
   logic [RCS_STRAP_W-1:0] cs0_r,      cs0_nxt;

   // Registered pin and reset lines
   logic                   tri_r,      tri_nxt;
   logic                   reset_out_b_r,   reset_out_b_nxt;
   logic                   core_r,     core_nxt;
   logic                   dram_r,     dram_nxt;

   // Synchronised request levels, active high
   logic                   ext_req;
   logic                   mst_req;
   // Watchdog event accepted this cycle
   logic                   wdog_start;

   // Request timing, in enabled rising edges of clock:
   //   edge 0     pin seen low by stage one
   //   edge 1     stage two low, request visible to the decode
   //   edge 2     hold state entered; reset out, core reset,
   //              bus float and cause flags all show here
   //   release    same two-edge lag, then 32 stretch cycles
   // Watchdog timing, from the edge that takes the timeout:
   //   edge 0     hold state entered, internal reset starts
   //   edge 31    stretch state, core reset still held
   //   edge 62    reset out lifts after 31 more cycles
   // Limitations:
   //   A timeout arriving while any reset runs is dropped; the
   //   watchdog restarts with the core anyway, so nothing is lost.
   //   A request shorter than one cycle may slip between samples
   //   and never be seen; outside circuitry holds it six cycles.
   //   Straps pass the same two stages as the request, so they
   //   line up with the request cycle that takes them.
   //   The master marker follows both pins cycle by cycle; a
   //   tri-state request that drops early turns the reset into
   //   a normal one and lets DRAM refresh resume.
   //   DRAM reset is held only while the master request is held;
   //   the stretch keeps the core in reset but not the DRAM
   //   controller, so refresh may start before the core runs.
   //   Clock enable low freezes every stage, counter and flag, so
   //   each figure above counts enabled cycles, not clock periods.
   //   The bus stays floated after reset out lifts until the core
   //   reports its first cycle; a core that never starts keeps it
   //   floated for good.

   // Count helper: cast a cycle figure to counter width
   function automatic logic [RCS_CNT_W-1:0] rcs_cnt(input int n);
      return RCS_CNT_W'(n);
   endfunction

   // Any state but idle keeps a reset running
   function automatic logic rcs_busy(input rcs_state_t st);
      return (st != RCS_IDLE);
   endfunction

   // Counter reached its last cycle
   function automatic logic rcs_cnt_done(input logic [RCS_CNT_W-1:0] c);
      return (c == '0);
   endfunction

   // Reset request synchroniser; idles negated so no false request
   // follows reset
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         rreq_s1_r <= 1'h1;
         rreq_s2_r <= 1'h1;
      end else if (clk_en) begin
         rreq_s1_r <= reset_request_in_b;
         rreq_s2_r <= rreq_s1_r;
      end
   end

   // Tri-state request synchroniser, same depth so both pins line up
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         treq_s1_r <= 1'h1;
         treq_s2_r <= 1'h1;
      end else if (clk_en) begin
         treq_s1_r <= tristate_request_in_b;
         treq_s2_r <= treq_s1_r;
      end
   end

   // Strap synchroniser; straps settle while the request is held
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         strap_s1_r <= RCS_STRAP_RST;
         strap_s2_r <= RCS_STRAP_RST;
      end else if (clk_en) begin
         strap_s1_r <= level_strap_pins;
         strap_s2_r <= strap_s1_r;
      end
   end

   // Tri-state request only counts alongside the reset request
   assign ext_req    = ~rreq_s2_r;
   assign mst_req    = ~rreq_s2_r & ~treq_s2_r;
   // Watchdog heard only from idle; an external request wins a tie
   assign wdog_start = (state_r == RCS_IDLE) && wdog_timeout && !ext_req;

   // Next state and counter of the sequencer
   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      unique case (state_r)
         RCS_IDLE: begin
            if (ext_req) begin
               state_nxt = RCS_EXT_HOLD;
            end else if (wdog_start) begin
               state_nxt = RCS_WDOG_HOLD;
               cnt_nxt   = rcs_cnt(RCS_WDOG_HOLD_CYC - 1);
            end
         end
         RCS_EXT_HOLD: begin
            // Stretch starts once the synchronised request lifts
            if (!ext_req) begin
               state_nxt = RCS_EXT_STRETCH;
               cnt_nxt   = rcs_cnt(RCS_EXT_STRETCH_CYC - 1);
            end
         end
         RCS_EXT_STRETCH: begin
            // A fresh request restarts the hold; the count reloads in full when it lifts
            if (ext_req) begin
               state_nxt = RCS_EXT_HOLD;
            end else if (rcs_cnt_done(cnt_r)) begin
               state_nxt = RCS_IDLE;
            end else begin
               cnt_nxt = cnt_r - 1'h1;
            end
         end
         RCS_WDOG_HOLD: begin
            // External request overrides the watchdog sequence
            if (ext_req) begin
               state_nxt = RCS_EXT_HOLD;
            end else if (rcs_cnt_done(cnt_r)) begin
               state_nxt = RCS_WDOG_STRETCH;
               cnt_nxt   = rcs_cnt(RCS_WDOG_STRETCH_CYC - 1);
            end else begin
               cnt_nxt = cnt_r - 1'h1;
            end
         end
         RCS_WDOG_STRETCH: begin
            if (ext_req) begin
               state_nxt = RCS_EXT_HOLD;
            end else if (rcs_cnt_done(cnt_r)) begin
               state_nxt = RCS_IDLE;
            end else begin
               cnt_nxt = cnt_r - 1'h1;
            end
         end
      endcase
   end

   // Sequencer registers
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         state_r <= RCS_IDLE;
         cnt_r   <= '0;
      end else if (clk_en) begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
      end
   end

   // Cause flags, master marker and strap copy. Every synchronised
   // request cycle refreshes them, the first one included, so the
   // last asserted cycle sticks; the watchdog leaves the straps alone
   always_comb begin
      master_nxt = master_r;
      hard_nxt   = hard_r;
      soft_nxt   = soft_r;
      cs0_nxt    = cs0_r;
      if (ext_req) begin
         master_nxt = mst_req;
         cs0_nxt    = strap_s2_r;
         hard_nxt   = 1'h1;
         soft_nxt   = 1'h0;
      end else if (wdog_start) begin
         // Strap copy untouched here
         master_nxt = 1'h0;
         hard_nxt   = 1'h0;
         soft_nxt   = 1'h1;
      end else if (!rcs_busy(state_nxt)) begin
         master_nxt = 1'h0;
      end
   end

   // Cause registers; flags keep their value until the next reset
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         master_r <= 1'h0;
         hard_r   <= RCS_HARD_FLAG_RST;
         soft_r   <= RCS_SOFT_FLAG_RST;
         cs0_r    <= RCS_STRAP_RST;
      end else if (clk_en) begin
         master_r <= master_nxt;
         hard_r   <= hard_nxt;
         soft_r   <= soft_nxt;
         cs0_r    <= cs0_nxt;
      end
   end

   // Pin and reset line decode from the next state, so every output
   // is a flop and shows the reset in the same cycle as the state
   always_comb begin
      reset_out_b_nxt = !rcs_busy(state_nxt);
      core_nxt   = rcs_busy(state_nxt);
      // DRAM controller and refresh reset only by a master reset
      dram_nxt   = (state_nxt == RCS_EXT_HOLD) && master_nxt;
      // Bus floats from any reset until the core's first cycle;
      // a late first cycle only delays the release
      tri_nxt    = tri_r;
      if (rcs_busy(state_nxt)) begin
         tri_nxt = 1'h1;
      end else if (first_exception_cycle) begin
         tri_nxt = 1'h0;
      end
   end

   // Output registers; reset shows every internal reset line active
   // and the bus floated, reset out itself stays negated
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         tri_r    <= 1'h1;
         reset_out_b_r <= 1'h1;
         core_r   <= 1'h1;
         dram_r   <= 1'h1;
      end else if (clk_en) begin
         tri_r    <= tri_nxt;
         reset_out_b_r <= reset_out_b_nxt;
         core_r   <= core_nxt;
         dram_r   <= dram_nxt;
      end
   end

   // Pins and flags straight from flops
   assign reset_out_b        = reset_out_b_r;
   assign core_reset         = core_r;
   assign dram_ctrl_reset    = dram_r;
   assign bus_tristate       = tri_r;
   assign hard_reset_flag    = hard_r;
   assign soft_reset_flag    = soft_r;
   assign chip_select0_strap = cs0_r;

endmodule // rcs_reset_sequencer

// ### rcs_pkg.sv
package rcs_pkg;
   // Synchroniser depth for the external reset inputs
   localparam int          RCS_SYNC_STAGES      = 2;
   // Reset-out stretch after external request negates
   localparam int          RCS_EXT_STRETCH_CYC  = 32;
   // Least internal watchdog reset length and reset-out stretch after it
   localparam int          RCS_WDOG_HOLD_CYC    = 31;
   localparam int          RCS_WDOG_STRETCH_CYC = 31;
   // Counter width covering every count above
   localparam int          RCS_CNT_W            = 6;
   // Strap pin width
   localparam int          RCS_STRAP_W          = 3;
   // Reset values
   localparam logic [2:0]  RCS_STRAP_RST        = 3'h7;
   localparam logic        RCS_HARD_FLAG_RST    = 1'h1;
   localparam logic        RCS_SOFT_FLAG_RST    = 1'h0;
   // Sequencer states
   typedef enum logic [2:0] {
      RCS_IDLE,
      RCS_EXT_HOLD,
      RCS_EXT_STRETCH,
      RCS_WDOG_HOLD,
      RCS_WDOG_STRETCH
   } rcs_state_t;
endpackage

// ### rcs_reset_sequencer_chk.sv
`timescale 1ns/1ps
module rcs_reset_sequencer_chk
   import rcs_pkg::*;
(
   // Clock, reset, enable and request pins
   input wire logic                   clock, rst_b, clk_en,
   input wire logic                   reset_request_in_b, tristate_request_in_b, wdog_timeout,
   // Reset outputs, cause flags and strap copy
   input wire logic                   reset_out_b, core_reset, dram_ctrl_reset, bus_tristate,
   input wire logic                   hard_reset_flag, soft_reset_flag,
   input wire logic [RCS_STRAP_W-1:0] chip_select0_strap
);
   logic [6:0] low_cnt_r;
   logic [6:0] low_cnt_nxt;
   // Cycles reset out has been low, saturating so it never wraps
   always_comb low_cnt_nxt = reset_out_b ? 7'h00 : low_cnt_r + {6'h00, low_cnt_r != 7'h7F};
   always_ff @(posedge clock) low_cnt_r <= low_cnt_nxt;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b || !clk_en);
   AST_WDOG_ANSWER: assert property (!core_reset && wdog_timeout && reset_request_in_b &&
      $past(reset_request_in_b) && $past(reset_request_in_b, 2) |=> !reset_out_b &&
      soft_reset_flag && !hard_reset_flag && !dram_ctrl_reset) else $error("watchdog answer");
   AST_WDOG_LEN: assert property ($rose(reset_out_b) && soft_reset_flag |->
      low_cnt_r >= 7'h3E) else $error("watchdog reset out too short");
   AST_EXT_ASSERT: assert property (!$past(reset_request_in_b, 3) && $past(rst_b, 3) |->
      !reset_out_b && core_reset && hard_reset_flag && !soft_reset_flag) else $error("ext answer");
   AST_EXT_STRETCH: assert property ($rose(reset_out_b) && hard_reset_flag |->
      $past(reset_request_in_b, 32) && !$past(reset_request_in_b, 40)) else $error("stretch");
   AST_DRAM_MASTER: assert property (!$past(reset_request_in_b, 3) && $past(rst_b, 3) &&
      !$past(tristate_request_in_b, 3) |-> dram_ctrl_reset) else $error("dram not reset");
   AST_DRAM_KEEP: assert property ($past(tristate_request_in_b, 3) && $past(rst_b, 4) &&
      $past(tristate_request_in_b, 4) |-> !dram_ctrl_reset) else $error("dram reset");
   AST_STRAP_HOLD: assert property ($changed(chip_select0_strap) |->
      hard_reset_flag && !reset_out_b) else $error("strap changed outside ext reset");
   AST_BUS_FLOAT: assert property (!reset_out_b |-> bus_tristate && core_reset)
      else $error("bus driven in reset");
   // Main scenarios reached
   cover property ($rose(reset_out_b) && soft_reset_flag);
   cover property (dram_ctrl_reset && !reset_out_b);
   cover property ($changed(chip_select0_strap));
endmodule // rcs_reset_sequencer_chk
bind rcs_reset_sequencer rcs_reset_sequencer_chk chk (.clock, .rst_b, .clk_en,
   .reset_request_in_b, .tristate_request_in_b, .wdog_timeout, .reset_out_b, .core_reset,
   .dram_ctrl_reset, .bus_tristate, .hard_reset_flag, .soft_reset_flag, .chip_select0_strap);

// ### rcs_ext_reset_model.sv
`timescale 1ns/1ps
module rcs_ext_reset_model
   import rcs_pkg::*;
(
   // Clock
   input  wire logic                   clock,
   // Reset pins toward the sequencer
   output logic                        reset_request_in_b,
   output logic                        tristate_request_in_b,
   output logic [RCS_STRAP_W-1:0]      level_strap_pins,
   // Transfer start from other bus masters, active low
   output logic                        transfer_start_n
);
   // Pins idle negated; no other master starts a cycle in reset
   initial begin
      transfer_start_n = 1'b1;
      reset_request_in_b = 1'b1;
      tristate_request_in_b = 1'b1;
      level_strap_pins = '0;
   end
   // Tri-state pin drops with the reset pin only for a master request; straps are held one cycle past release
   task automatic request(input logic master, input int len, input logic [2:0] strap);
      @(negedge clock);
      level_strap_pins = strap;
      reset_request_in_b = 1'b0;
      tristate_request_in_b = !master;
      repeat (len) @(negedge clock);
      reset_request_in_b = 1'b1;
      tristate_request_in_b = 1'b1;
      @(negedge clock);
      level_strap_pins = ~strap;
   endtask
endmodule // rcs_ext_reset_model

// ### rcs_reset_sequencer_test.sv
`timescale 1ns/1ps
`define CHK(n, g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("CHECK FAILED %s expected %0h seen %0h", n, e, g); end end
module rcs_reset_sequencer_test;
   import rcs_pkg::*;
   logic       clock, rst_b, clk_en, wdog_timeout, first_exception_cycle;
   logic       reset_request_in_b, tristate_request_in_b, reset_out_b, core_reset;
   logic       dram_ctrl_reset, bus_tristate, hard_reset_flag, soft_reset_flag;
   logic [2:0] level_strap_pins, chip_select0_strap;
   logic       transfer_start_n;
   int         error_cnt = 0;
   int         checks = 0;
   rcs_ext_reset_model model (.clock, .reset_request_in_b, .tristate_request_in_b,
      .level_strap_pins, .transfer_start_n);
   rcs_reset_sequencer uut (.clock, .rst_b, .clk_en, .reset_request_in_b,
      .tristate_request_in_b, .level_strap_pins, .wdog_timeout, .first_exception_cycle,
      .reset_out_b, .core_reset, .dram_ctrl_reset, .bus_tristate, .hard_reset_flag,
      .soft_reset_flag, .chip_select0_strap);
   // 250 MHz clock
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   task automatic final_report();
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Count cycles until reset out lifts, then hand the bus to the core
   task automatic finish_reset(output int lows);
      lows = 0;
      while (reset_out_b !== 1'b1 && lows < 200) begin
         @(negedge clock);
         lows++;
      end
      if (lows >= 200) begin
         error_cnt++;
         final_report();
      end
      `CHK("bus_float", bus_tristate, 1'b1)
      first_exception_cycle = 1'b1;
      @(negedge clock);
      first_exception_cycle = 1'b0;
      @(negedge clock);
      `CHK("bus_free", bus_tristate, 1'b0)
   endtask
   task automatic ext_reset(input logic master, input logic [2:0] strap);
      int lows;
      fork
         model.request(master, 6, strap);
      join_none
      repeat (5) @(negedge clock);
      `CHK("out_low", reset_out_b, 1'b0)
      `CHK("ts_negated", transfer_start_n, 1'b1)
      `CHK("dram", dram_ctrl_reset, master)
      finish_reset(lows);
      `CHK("stretch", lows >= 32, 1'b1)
      `CHK("hard", hard_reset_flag, 1'b1)
      `CHK("soft", soft_reset_flag, 1'b0)
      `CHK("strap", chip_select0_strap, strap)
   endtask
   // Watchdog reset, optionally overtaken by an external request
   task automatic wdog_reset(input logic ext);
      int lows;
      logic [2:0] keep;
      keep = chip_select0_strap;
      @(negedge clock);
      wdog_timeout = 1'b1;
      @(negedge clock);
      wdog_timeout = 1'b0;
      `CHK("wd_out", reset_out_b, 1'b0)
      `CHK("wd_dram", dram_ctrl_reset, 1'b0)
      if (ext) begin
         repeat (10) @(negedge clock);
         model.request(1'b0, 6, 3'h6);
         keep = 3'h6;
      end else begin
         // Frozen cycles must not count toward the watchdog hold
         clk_en = 1'b0;
         repeat (4) @(negedge clock);
         clk_en = 1'b1;
      end
      finish_reset(lows);
      `CHK("wd_len", lows >= (ext ? 32 : 62), 1'b1)
      `CHK("wd_hard", hard_reset_flag, ext)
      `CHK("wd_soft", soft_reset_flag, !ext)
      `CHK("wd_strap", chip_select0_strap, keep)
   endtask
   initial begin
      rst_b = 1'b0;
      clk_en = 1'b1;
      wdog_timeout = 1'b0;
      first_exception_cycle = 1'b0;
      repeat (2) @(negedge clock);
      rst_b = 1'b1;
      `CHK("rst_out", reset_out_b, 1'b1)
      ext_reset(1'b1, 3'h5);
      ext_reset(1'b0, 3'h2);
      wdog_reset(1'b0);
      wdog_reset(1'b1);
      ext_reset(1'b1, 3'h0);
      final_report();
   end
endmodule // rcs_reset_sequencer_test
